// File: hw/ssd_core.sv
// Functional notes
// - Manual mode: field bit drives select line.
// - Auto mode: select active only during transfer.
// - Select polarity follows active-level bit always.
// - Slave mode: select is input, never driven.
// - Receive words hold last completed transfer data.
// - Valid receive bits follow word bit length.
// - Bus writes never change receive registers.
// - Active-level bit: 0 low, 1 high.
// - Go asserts auto select; finish releases it.
// - Transmit words feed transfer, word 0 first.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_cfg.svh"

module ssd_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk_i,
  input wire logic sdi,
  input wire logic ss_i,
  output ssd_pkg::ssd_pins_t pins
);
  import ssd_pkg::*;

  // ========================================================
  // Helpers
  // ========================================================
  // A length field of zero means a full 32-bit word.
  function automatic logic [5:0] eff_len(input logic [4:0] f);
    eff_len = (f == 5'h00) ? `SSD_FULL_LEN : {1'b0, f};
  endfunction

  // Left-justify the valid bits so the MSB leaves first.
  function automatic logic [31:0] tx_align(input logic [31:0] d,
                                           input logic [5:0] n);
    tx_align = d << (`SSD_FULL_LEN - n);
  endfunction

  // ========================================================
  // Registers and state
  // ========================================================
  logic go_q, slave_q, cnt_q, line_q, pol_q, auto_q;
  logic [4:0] len_q;
  logic [31:0] rx0_q, rx1_q, tx0_q, tx1_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  ssd_state_t state_q;
  logic [31:0] txsh_q, rxsh_q;
  logic [5:0] bitcnt_q;
  logic widx_q;
  logic [2:0] div_q;
  logic sclk_q, sdo_q, ss_o_q, ss_oe_q;
  logic sclk_s1, sclk_s2, sclk_s3;
  logic sdi_s1, sdi_s2;
  logic ssi_s1, ssi_s2;

  // ========================================================
  // APB decode
  // ========================================================
  // One wait state: pready rises in the second access cycle.
  wire logic acc = psel & penable;
  wire logic wr_en = acc & pwrite & pready_q;
  wire logic rd_take = acc & ~pwrite & ~pready_q;
  wire logic hit_ctrl = (paddr == `SSD_OFS_CTRL);
  wire logic hit_sel = (paddr == `SSD_OFS_SEL);
  wire logic hit_rx0 = (paddr == `SSD_OFS_RX0);
  wire logic hit_rx1 = (paddr == `SSD_OFS_RX1);
  wire logic hit_tx0 = (paddr == `SSD_OFS_TX0);
  wire logic hit_tx1 = (paddr == `SSD_OFS_TX1);
  wire logic mapped = hit_ctrl | hit_sel | hit_rx0 | hit_rx1 |
                      hit_tx0 | hit_tx1;
  wire logic busy = (state_q != ST_IDLE);
  wire logic [5:0] nbits = eff_len(len_q);

  // Read mux; transmit words read back as zero.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `SSD_RST_WORD;
    if (hit_ctrl) begin
      rd_mux[`SSD_CTRL_GO] = go_q;
      rd_mux[`SSD_CTRL_SLAVE] = slave_q;
      rd_mux[`SSD_CTRL_BUSY] = busy;
      rd_mux[`SSD_CTRL_LEN_HI:`SSD_CTRL_LEN_LO] = len_q;
      rd_mux[`SSD_CTRL_CNT] = cnt_q;
    end else if (hit_sel) begin
      rd_mux[`SSD_SEL_LINE] = line_q;
      rd_mux[`SSD_SEL_POL] = pol_q;
      rd_mux[`SSD_SEL_AUTO] = auto_q;
    end else if (hit_rx0) begin
      rd_mux = rx0_q;
    end else if (hit_rx1) begin
      rd_mux = rx1_q;
    end else begin
      rd_mux = `SSD_RST_WORD;
    end
  end

  // Bus answer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `SSD_RST_WORD;
    end else begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~mapped;
      if (rd_take) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ========================================================
  // Software-written registers
  // ========================================================
  // The receive offsets are left out here, so writes there
  // are acknowledged and dropped.
  wire logic fin = (state_q == ST_DONE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_q <= 1'b0;
      len_q <= 5'h00;
      cnt_q <= 1'b0;
      line_q <= 1'b0;
      pol_q <= 1'b0;
      auto_q <= 1'b0;
      tx0_q <= `SSD_RST_WORD;
      tx1_q <= `SSD_RST_WORD;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        slave_q <= pwdata[`SSD_CTRL_SLAVE];
        len_q <= pwdata[`SSD_CTRL_LEN_HI:`SSD_CTRL_LEN_LO];
        cnt_q <= pwdata[`SSD_CTRL_CNT];
      end else if (hit_sel) begin
        line_q <= pwdata[`SSD_SEL_LINE];
        pol_q <= pwdata[`SSD_SEL_POL];
        auto_q <= pwdata[`SSD_SEL_AUTO];
      end else if (hit_tx0) begin
        tx0_q <= pwdata;
      end else if (hit_tx1) begin
        tx1_q <= pwdata;
      end
    end
  end

  // Go bit: a software set wins over the finish clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q <= 1'b0;
    end else if (wr_en & hit_ctrl & pwdata[`SSD_CTRL_GO]) begin
      go_q <= 1'b1;
    end else if (fin) begin
      go_q <= 1'b0;
    end
  end

  // ========================================================
  // Pin synchronisers
  // ========================================================
  // Edge detection reads only the second stage and beyond.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      ssi_s1 <= 1'b1;
      ssi_s2 <= 1'b1;
    end else begin
      sclk_s1 <= sclk_i;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sdi_s1 <= sdi;
      sdi_s2 <= sdi_s1;
      ssi_s1 <= ss_i;
      ssi_s2 <= ssi_s1;
    end
  end

  // ========================================================
  // Serial clock events
  // ========================================================
  // In master mode the divider tick toggles our own clock; in
  // slave mode the remote master's clock edges are used.
  wire logic tick = (div_q == 3'(`SSD_HALF_CYC - 1));
  wire logic m_run = ~slave_q & (state_q == ST_SHIFT);
  wire logic rise_ev = slave_q ? (sclk_s2 & ~sclk_s3)
                               : (m_run & tick & ~sclk_q);
  wire logic fall_ev = slave_q ? (~sclk_s2 & sclk_s3)
                               : (m_run & tick & sclk_q);
  wire logic ss_in_act = (ssi_s2 == pol_q);
  wire logic last_bit = (bitcnt_q == nbits);

  // Half-period divider, held at zero outside a master word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 3'h0;
    end else if (!m_run || tick) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // ========================================================
  // Two-entry receive buffer
  // ========================================================
  // The drain stalls while software reads a receive word so a
  // read never sees half of an update; the shifter waits in the
  // push state only once both buffer entries are full.
  ssd_rx_word_t buf_q [2];
  logic wp_q, rp_q;
  logic [1:0] fill_q;
  wire logic in_valid = (state_q == ST_PUSH);
  wire logic in_ready = (fill_q != 2'h2);
  wire logic out_valid = (fill_q != 2'h0);
  wire logic out_ready = ~(acc & (hit_rx0 | hit_rx1));
  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;
  wire ssd_rx_word_t in_word = '{idx: widx_q, data: rxsh_q};
  wire ssd_rx_word_t out_word = buf_q[rp_q];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      fill_q <= 2'h0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (push) begin
        buf_q[wp_q] <= in_word;
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Receive words change only from the buffer, never the bus.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx0_q <= `SSD_RST_WORD;
      rx1_q <= `SSD_RST_WORD;
    end else if (pop) begin
      if (out_word.idx) begin
        rx1_q <= out_word.data;
      end else begin
        rx0_q <= out_word.data;
      end
    end
  end

  // ========================================================
  // Shifter state machine
  // ========================================================
  // Master mode starts on go; slave mode starts when the remote
  // master asserts select. Edges that arrive while a slave word
  // waits in the push state are lost, so the remote clock must
  // leave a gap between words if the bus stalls the drain.
  logic start;
  assign start = slave_q ? ss_in_act : go_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      txsh_q <= `SSD_RST_WORD;
      rxsh_q <= `SSD_RST_WORD;
      bitcnt_q <= 6'h00;
      widx_q <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sclk_q <= 1'b0;
          bitcnt_q <= 6'h00;
          widx_q <= 1'b0;
          rxsh_q <= `SSD_RST_WORD;
          if (start) begin
            txsh_q <= tx_align(tx0_q, nbits);
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!slave_q && tick) begin
            sclk_q <= ~sclk_q;
          end
          if (slave_q && !ss_in_act) begin
            state_q <= ST_DONE;
          end else if (rise_ev) begin
            rxsh_q <= {rxsh_q[30:0], sdi_s2};
            bitcnt_q <= bitcnt_q + 6'h01;
          end else if (fall_ev) begin
            if (last_bit) begin
              state_q <= ST_PUSH;
            end else begin
              txsh_q <= {txsh_q[30:0], 1'b0};
            end
          end
        end
        ST_PUSH: begin
          if (push) begin
            bitcnt_q <= 6'h00;
            rxsh_q <= `SSD_RST_WORD;
            if (cnt_q && !widx_q) begin
              widx_q <= 1'b1;
              txsh_q <= tx_align(tx1_q, nbits);
              state_q <= ST_SHIFT;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // A slave re-arms only after select goes inactive.
          if (!slave_q || !ss_in_act) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // Select line and pin registers
  // ========================================================
  // Auto mode asserts the nominated line from go until the last
  // word is pushed; manual mode follows the field directly.
  wire logic xfer_on = (state_q == ST_SHIFT) | (state_q == ST_PUSH);
  wire logic sel_act = auto_q ? (line_q & go_q & xfer_on)
                              : line_q;
  wire logic slave_d = (wr_en & hit_ctrl) ? pwdata[`SSD_CTRL_SLAVE] : slave_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_o_q <= 1'b1;
      ss_oe_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      ss_o_q <= sel_act ? pol_q : ~pol_q;
      ss_oe_q <= ~slave_d;
      sdo_q <= xfer_on ? txsh_q[31] : 1'b0;
    end
  end

  // ========================================================
  // Outputs
  // ========================================================
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pins.sclk_o = sclk_q;
  assign pins.sclk_oe = ~slave_q;
  assign pins.sdo = sdo_q;
  assign pins.ss_o = ss_o_q;
  assign pins.ss_oe = ss_oe_q;

endmodule
`default_nettype wire

// File: hw/ssd_cfg.svh
`ifndef SSD_CFG_SVH
`define SSD_CFG_SVH

// ==========================================================
// Register offsets (byte addresses on APB)
// ==========================================================
`define SSD_OFS_CTRL 8'h00
`define SSD_OFS_SEL 8'h08
`define SSD_OFS_RX0 8'h10
`define SSD_OFS_RX1 8'h14
`define SSD_OFS_TX0 8'h20
`define SSD_OFS_TX1 8'h24

// ==========================================================
// Field positions
// ==========================================================
`define SSD_CTRL_GO 0
`define SSD_CTRL_SLAVE 1
`define SSD_CTRL_BUSY 2
`define SSD_CTRL_LEN_LO 8
`define SSD_CTRL_LEN_HI 12
`define SSD_CTRL_CNT 16
`define SSD_SEL_LINE 0
`define SSD_SEL_POL 2
`define SSD_SEL_AUTO 3

// ==========================================================
// Reset values and timing
// ==========================================================
`define SSD_RST_WORD 32'h0000_0000
`define SSD_FULL_LEN 6'h20
`define SSD_PCLK_MHZ 50
`define SSD_SCLK_HALF_NS 80
`define SSD_HALF_CYC ((`SSD_SCLK_HALF_NS * `SSD_PCLK_MHZ) / 1000)

`endif

// File: hw/ssd_pkg.sv
`default_nettype none
package ssd_pkg;

  // Shifter states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_PUSH = 2'b10,
    ST_DONE = 2'b11
  } ssd_state_t;

  // One received word on its way to the receive registers.
  typedef struct packed {
    logic idx;
    logic [31:0] data;
  } ssd_rx_word_t;

  // Serial pin group driven by the block.
  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic sdo;
    logic ss_o;
    logic ss_oe;
  } ssd_pins_t;

endpackage
`default_nettype wire

// File: verif/ssd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checks for the select and data register block.
module ssd_core_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sclk_i,
  input wire logic sdi,
  input wire logic ss_i,
  input wire ssd_pkg::ssd_pins_t pins
);
  import ssd_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decoded bus events; a select write in manual mode sets the pin level.
  wire logic acc_end = psel && penable && pready;
  wire logic mapped = paddr inside {8'h00, 8'h08, 8'h10, 8'h14, 8'h20, 8'h24};
  wire logic tx_rd = acc_end && !pwrite && (paddr == 8'h20 || paddr == 8'h24);
  wire logic sel_wr = acc_end && pwrite && paddr == 8'h08 && !pwdata[3];
  logic exp_ss_q;
  // The expected level is held here, as pwdata moves on after the write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_ss_q <= 1'b1;
    end else if (sel_wr) begin
      exp_ss_q <= pwdata[0] ~^ pwdata[2];
    end
  end
  a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (acc_end |-> pslverr == !mapped)
    else $error("pslverr does not match the address map");
  a_tx_read_zero: assert property (tx_rd |-> prdata == 32'h0)
    else $error("transmit read not zero");
  a_manual_sel: assert property (sel_wr && pins.ss_oe |=> ##1
    pins.ss_o == exp_ss_q) else $error("manual select level wrong");
  a_slave_no_oe: assert property (!pins.sclk_oe |-> !pins.ss_oe)
    else $error("select driven in slave mode");
  a_sclk_half: assert property ($rose(pins.sclk_o) |->
    pins.sclk_o [*4] ##1 !pins.sclk_o) else $error("clock high time wrong");
  a_sdo_steady: assert property ($rose(pins.sclk_o) |-> $stable(pins.sdo))
    else $error("data moved at the sampling edge");
  c_sel_write: cover property (sel_wr);
  c_link_edge: cover property ($rose(pins.sclk_o));
  c_refused: cover property (acc_end && pslverr);
endmodule
bind ssd_core ssd_core_chk u_ssd_core_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sclk_i, .sdi,
  .ss_i, .pins);
`default_nettype wire

// File: verif/ssd_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Remote slave in mode 0, most significant bit first.
module ssd_peer (
  input wire logic sclk,
  input wire logic ss,
  input wire logic pol,
  input wire logic mosi,
  input wire logic [63:0] reply,
  output logic miso,
  output logic [63:0] got
);
  logic [63:0] sh = 64'h0;
  initial begin
    miso = 1'b0;
    got = 64'h0;
  end
  // On release the line flips, so a stale bit never passes for data.
  always @(ss or pol) begin
    if (ss === pol) begin
      sh = reply;
      miso = sh[63];
    end else begin
      miso = ~miso;
    end
  end
  // Sample on the rising edge, shift on the falling edge.
  always @(posedge sclk) begin
    if (ss === pol) got = {got[62:0], mosi};
  end
  always @(negedge sclk) begin
    if (ss === pol) begin
      sh = sh << 1;
      miso = sh[63];
    end
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench driving the register bus and both link roles.
module tb;
  import ssd_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sclk_i = 1'b0, ss_i = 1'b1, sdi_tb = 1'b0;
  logic slv = 1'b0, pol = 1'b0, pready, pslverr, miso, last_err;
  logic [7:0] paddr = 8'h00, sb = 8'h96;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [63:0] reply = 64'h0, got;
  int n_mismatch = 0, compares = 0;
  ssd_pins_t pins;
  // In slave mode the bench is the remote master on the data line.
  wire logic sdi = slv ? sdi_tb : miso;
  wire logic peer_ss = pins.ss_oe ? pins.ss_o : !pol;
  always #10 pclk = ~pclk;
  ssd_core u_ssd_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sclk_i, .sdi, .ss_i, .pins);
  ssd_peer u_ssd_peer (.sclk(pins.sclk_o), .ss(peer_ss), .pol,
    .mosi(pins.sdo), .reply, .miso, .got);
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  // The request is held until pready is seen high at an edge.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  // Writes the select field and checks the pin once it has settled.
  task automatic sel(input logic [31:0] d, input logic e);
    pol <= d[2];
    wr(8'h08, d);
    repeat (2) @(posedge pclk);
    chk(pins.ss_o, e);
  endtask
  // Polling is bounded so a stuck busy flag ends in a mismatch.
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      xfer(1'b0, 8'h00, 32'h0);
      k++;
    end while (rdv[2] !== 1'b0 && k < 300);
    if (rdv[2] !== 1'b0) n_mismatch++;
    repeat (2) @(posedge pclk);
  endtask
  // The link clock only runs inside a frame, 160 ns per bit.
  task automatic send_bit(input logic b);
    sdi_tb <= b;
    repeat (4) @(posedge pclk);
    sclk_i <= 1'b1;
    repeat (4) @(posedge pclk);
    sclk_i <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h30, 32'h0);
    chk(last_err, 1'b1);
    sel(32'h1, 1'b0);
    sel(32'h5, 1'b1);
    sel(32'h4, 1'b0);
    // One byte under hand-driven select.
    reply <= {8'h3C, 56'h0};
    sel(32'h1, 1'b0);
    wr(8'h20, 32'h0000_00A5);
    rd(8'h20, 32'h0);
    wr(8'h00, 32'h0000_0801);
    wait_idle();
    rd(8'h10, 32'h0000_003C);
    chk(got[7:0], 8'hA5);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_003C);
    // Two full words with automatic select.
    reply <= 64'hCAFE_F00D_0BAD_BEEF;
    sel(32'h9, 1'b1);
    wr(8'h20, 32'h1234_5678);
    wr(8'h24, 32'h9ABC_DEF0);
    wr(8'h00, 32'h0001_0001);
    repeat (20) @(posedge pclk);
    chk(pins.ss_o, 1'b0);
    wait_idle();
    chk(pins.ss_o, 1'b1);
    chk(got, 64'h1234_5678_9ABC_DEF0);
    rd(8'h14, 32'h0BAD_BEEF);
    // Slave role: a remote master clocks one byte in.
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h0000_0802);
    repeat (2) @(posedge pclk);
    chk(pins.ss_oe, 1'b0);
    chk(pins.sclk_oe, 1'b0);
    slv <= 1'b1;
    ss_i <= 1'b0;
    for (int i = 7; i >= 0; i--) send_bit(sb[i]);
    repeat (4) @(posedge pclk);
    ss_i <= 1'b1;
    sdi_tb <= ~sdi_tb;
    repeat (8) @(posedge pclk);
    rd(8'h10, 32'h0000_0096);
    tally_and_finish();
  end
endmodule
`default_nettype wire
